// ---- hw/omc_pkg.sv ----
// package: types and constants of the operating-mode controller
package omc_pkg;
	// ************************************
	// register port
	// ************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_FEEDBACK = 4'h8;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_G74_BIT = 1;
	localparam int CTRL_ERR_CLR_BIT = 2;
	localparam logic [7:0] BLOCK_PTR_RESET = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ************************************
	// enumerations
	// ************************************
	typedef enum logic [1:0] {
		MODE_AUTO,
		MODE_TRAVERSE,
		MODE_MDI
	} omc_mode_t;

	typedef enum logic [1:0] {
		CHAN_RESET,
		CHAN_INTR,
		CHAN_ACTIVE
	} omc_chan_t;

	typedef enum logic [1:0] {
		ORIG_NONE,
		ORIG_AUTO,
		ORIG_MDI
	} omc_orig_t;

	// ************************************
	// request and feedback carriers
	// ************************************
	typedef struct packed {
		logic sel_auto;
		logic sel_mdi;
		logic sel_traverse;
		logic mode_chg_disable;
		logic reset_req;
		logic ref_req;
		logic stop_axes;
		logic stop_axes_spindles;
		logic block_end_stop_request;
		logic interlock;
	} omc_req_t;

	typedef struct packed {
		logic act_auto;
		logic act_mdi;
		logic act_traverse;
		logic ref_active;
		logic ready;
		logic chan_reset;
		logic chan_intr;
		logic chan_active;
		logic mode_err;
		logic prep_halt;
		logic stop_axes_cmd;
		logic stop_spindles_cmd;
		logic aux_discard;
		logic alarm_clear;
		logic prog_run;
		logic g74_run;
		logic motion_enable;
	} omc_fb_t;
endpackage

// ---- hw/omc_mode_ctrl.sv ----
// module: single-channel operating-mode and channel-state controller
// Notes on behaviour
// - program execution is program operation, allowed only in auto and mdi modes.
// - one channel; exactly one operating mode valid at any time.
// - simultaneous selects: traverse wins, then mdi, auto only if alone.
// - in traverse mode channel requests other than reset, and interlocks, are ignored.
// - active mode reported on feedback bits separate from the request bits.
// - reference approach requested in traverse mode, acknowledged on feedback bit.
// - three stops: axes, axes plus spindles, axes at block end.
// - channel reset request aborts the running program.
// - reset halts preparation at once and stops axes and spindles.
// - reset discards unissued auxiliary functions of the current block.
// - reset returns the block pointer to the first block.
// - reset clears all reset-clearable alarms.
// - reset completion shown by channel-reset status bit.
// - ready bit driven whenever the block is able to run.
// - accepted mode change waits until channel-active drops.
// - in channel reset any mode change is accepted.
// - interrupted: only auto/mdi to traverse and traverse back to origin.
// - interrupted traverse blocks the indirect path to the other program mode.
// - illegal change rejected with an error clearable without state change.
// - mode-change disable suppresses new mode change requests; an already deferred change is still taken.
// - start only in auto/mdi with channel reset or interrupted; then active.
// - g74 reference command starts and runs only while active in auto/mdi.
`timescale 1ns/1ps
module omc_mode_ctrl (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire omc_pkg::omc_req_t i_req,
	input wire logic i_block_end,
	input wire logic i_prog_end,
	input wire logic i_g74_done,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output omc_pkg::omc_fb_t o_fb,
	output logic [7:0] o_block_ptr
);
	// ************************************
	// state
	// ************************************
	typedef struct packed {
		omc_pkg::omc_mode_t mode;
		omc_pkg::omc_chan_t chan;
		omc_pkg::omc_orig_t orig;
		logic pend;
		omc_pkg::omc_mode_t pend_mode;
		logic [1:0] last_sel;
		logic last_sel_vld;
		logic blk_stop;
		logic [7:0] block_ptr;
		logic [31:0] rdata;
		omc_pkg::omc_fb_t fb;
	} omc_state_t;

	omc_state_t st;
	omc_state_t next_st;

	logic sel_vld;
	omc_pkg::omc_mode_t sel_mode;
	logic new_sel;
	logic do_change;
	omc_pkg::omc_mode_t chg_mode;
	logic legal;
	logic start_cmd;
	logic g74_cmd;
	logic err_clr;
	logic in_trav;

	// ************************************
	// request decode
	// ************************************
	always_comb begin
		sel_vld = i_req.sel_traverse | i_req.sel_mdi | i_req.sel_auto;
		if (i_req.sel_traverse) begin
			sel_mode = omc_pkg::MODE_TRAVERSE;
		end else if (i_req.sel_mdi) begin
			sel_mode = omc_pkg::MODE_MDI;
		end else begin
			sel_mode = omc_pkg::MODE_AUTO;
		end
	end

	assign new_sel = sel_vld && !i_req.mode_chg_disable && sel_mode != st.mode &&
		!(st.last_sel_vld && st.last_sel == sel_mode);
	assign start_cmd = i_wr && i_addr == omc_pkg::ADDR_CTRL && i_wdata[omc_pkg::CTRL_START_BIT];
	assign g74_cmd = i_wr && i_addr == omc_pkg::ADDR_CTRL && i_wdata[omc_pkg::CTRL_G74_BIT];
	assign err_clr = i_wr && i_addr == omc_pkg::ADDR_CTRL && i_wdata[omc_pkg::CTRL_ERR_CLR_BIT];
	assign in_trav = st.mode == omc_pkg::MODE_TRAVERSE;

	// a deferred change is taken once the channel is no longer active
	always_comb begin
		if (st.pend && !new_sel) begin
			chg_mode = st.pend_mode;
		end else begin
			chg_mode = sel_mode;
		end
		do_change = (new_sel || st.pend) && st.chan != omc_pkg::CHAN_ACTIVE;
	end

	// ************************************
	// permitted transitions
	// ************************************
	always_comb begin
		legal = 1'b0;
		case (st.chan)
			omc_pkg::CHAN_RESET: begin
				legal = 1'b1;
			end
			omc_pkg::CHAN_INTR: begin
				case (st.mode)
					omc_pkg::MODE_AUTO: begin
						legal = chg_mode == omc_pkg::MODE_TRAVERSE;
					end
					omc_pkg::MODE_MDI: begin
						legal = chg_mode == omc_pkg::MODE_TRAVERSE;
					end
					omc_pkg::MODE_TRAVERSE: begin
						legal = (chg_mode == omc_pkg::MODE_AUTO && st.orig == omc_pkg::ORIG_AUTO) ||
							(chg_mode == omc_pkg::MODE_MDI && st.orig == omc_pkg::ORIG_MDI);
					end
					default: begin
						legal = 1'b0;
					end
				endcase
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	// ************************************
	// next state
	// ************************************
	always_comb begin
		next_st = st;
		next_st.fb.aux_discard = 1'b0;
		next_st.fb.alarm_clear = 1'b0;
		next_st.last_sel = sel_mode;
		next_st.last_sel_vld = sel_vld && !i_req.mode_chg_disable;

		// mode change
		if (new_sel && st.chan == omc_pkg::CHAN_ACTIVE) begin
			next_st.pend = 1'b1;
			next_st.pend_mode = sel_mode;
		end
		if (do_change) begin
			next_st.pend = 1'b0;
			if (chg_mode == st.mode) begin
				next_st.mode = st.mode;
			end else if (legal) begin
				next_st.mode = chg_mode;
				if (st.chan == omc_pkg::CHAN_INTR && chg_mode == omc_pkg::MODE_TRAVERSE) begin
					next_st.orig = st.mode == omc_pkg::MODE_AUTO ? omc_pkg::ORIG_AUTO : omc_pkg::ORIG_MDI;
				end else if (chg_mode != omc_pkg::MODE_TRAVERSE) begin
					next_st.orig = omc_pkg::ORIG_NONE;
				end
			end else begin
				next_st.fb.mode_err = 1'b1;
			end
		end else if (err_clr) begin
			next_st.fb.mode_err = 1'b0;
		end

		// channel-specific requests, ignored in traverse mode
		if (!in_trav) begin
			if (start_cmd && st.chan != omc_pkg::CHAN_ACTIVE && !st.pend && !do_change) begin
				next_st.chan = omc_pkg::CHAN_ACTIVE;
				next_st.fb.stop_axes_cmd = 1'b0;
				next_st.fb.stop_spindles_cmd = 1'b0;
				next_st.fb.prep_halt = 1'b0;
				next_st.blk_stop = 1'b0;
			end else if (st.chan == omc_pkg::CHAN_ACTIVE) begin
				if (i_req.stop_axes || i_req.stop_axes_spindles) begin
					next_st.chan = omc_pkg::CHAN_INTR;
					next_st.fb.stop_axes_cmd = 1'b1;
					next_st.fb.stop_spindles_cmd = i_req.stop_axes_spindles;
				end else if (i_prog_end) begin
					next_st.chan = omc_pkg::CHAN_RESET;
					next_st.block_ptr = omc_pkg::BLOCK_PTR_RESET;
				end else if (i_block_end) begin
					next_st.block_ptr = st.block_ptr + 8'h01;
					if (st.blk_stop || i_req.block_end_stop_request) begin
						next_st.chan = omc_pkg::CHAN_INTR;
						next_st.fb.stop_axes_cmd = 1'b1;
						next_st.blk_stop = 1'b0;
					end
				end else if (i_req.block_end_stop_request) begin
					next_st.blk_stop = 1'b1;
				end
			end
		end
		next_st.fb.g74_run = (st.fb.g74_run || g74_cmd) && !i_g74_done &&
			next_st.chan == omc_pkg::CHAN_ACTIVE && !in_trav;

		// channel reset
		if (i_req.reset_req) begin
			next_st.chan = omc_pkg::CHAN_RESET;
			next_st.fb.prep_halt = 1'b1;
			next_st.fb.stop_axes_cmd = 1'b1;
			next_st.fb.stop_spindles_cmd = 1'b1;
			next_st.fb.aux_discard = 1'b1;
			next_st.block_ptr = omc_pkg::BLOCK_PTR_RESET;
			next_st.fb.alarm_clear = 1'b1;
			next_st.fb.g74_run = 1'b0;
			next_st.orig = omc_pkg::ORIG_NONE;
			next_st.blk_stop = 1'b0;
		end

		// feedback, one mode and one channel state at a time
		next_st.fb.act_auto = next_st.mode == omc_pkg::MODE_AUTO;
		next_st.fb.act_mdi = next_st.mode == omc_pkg::MODE_MDI;
		next_st.fb.act_traverse = next_st.mode == omc_pkg::MODE_TRAVERSE;
		next_st.fb.ref_active = next_st.mode == omc_pkg::MODE_TRAVERSE && i_req.ref_req;
		next_st.fb.chan_reset = next_st.chan == omc_pkg::CHAN_RESET;
		next_st.fb.chan_intr = next_st.chan == omc_pkg::CHAN_INTR;
		next_st.fb.chan_active = next_st.chan == omc_pkg::CHAN_ACTIVE;
		next_st.fb.prog_run = next_st.chan == omc_pkg::CHAN_ACTIVE;
		next_st.fb.ready = !i_req.reset_req;
		next_st.fb.motion_enable = next_st.mode == omc_pkg::MODE_TRAVERSE ||
			(next_st.chan == omc_pkg::CHAN_ACTIVE && !i_req.interlock);

		// register read
		next_st.rdata = omc_pkg::RDATA_RESET;
		if (i_rd) begin
			case (i_addr)
				omc_pkg::ADDR_STATUS: begin
					next_st.rdata = {16'h0000, st.block_ptr, st.pend, st.orig, st.chan, st.mode, st.fb.mode_err};
				end
				omc_pkg::ADDR_FEEDBACK: begin
					next_st.rdata = {15'h0000, st.fb};
				end
				default: begin
					next_st.rdata = omc_pkg::RDATA_RESET;
				end
			endcase
		end
	end

	// ************************************
	// registers
	// ************************************
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
			st.mode <= omc_pkg::MODE_AUTO;
			st.chan <= omc_pkg::CHAN_RESET;
			st.fb.act_auto <= 1'b1;
			st.fb.chan_reset <= 1'b1;
			st.fb.prep_halt <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_fb = st.fb;
	assign o_block_ptr = st.block_ptr;

	// ************************************
	// checks
	// ************************************
	chk_chan_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$onehot({o_fb.chan_reset, o_fb.chan_intr, o_fb.chan_active}))
		else $error("channel status not one-hot");
	chk_mode_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$onehot({o_fb.act_auto, o_fb.act_mdi, o_fb.act_traverse}))
		else $error("active mode not one-hot");
	chk_reset_actions: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_req.reset_req |=> o_fb.chan_reset && o_fb.stop_axes_cmd && o_fb.stop_spindles_cmd &&
		o_fb.prep_halt && o_fb.aux_discard && o_fb.alarm_clear && o_block_ptr == 8'h00 && !o_fb.prog_run)
		else $error("reset actions missing");
	chk_sel_priority: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_fb.chan_reset && !i_req.reset_req && !i_req.mode_chg_disable && i_req.sel_traverse &&
		i_req.sel_mdi && !o_fb.act_traverse |=> o_fb.act_traverse)
		else $error("traverse did not win");
	chk_change_disable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_req.mode_chg_disable && !st.pend |=> $stable({o_fb.act_auto, o_fb.act_mdi, o_fb.act_traverse}))
		else $error("mode changed while disabled");
	chk_active_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		st.chan == omc_pkg::CHAN_ACTIVE |=> $stable(st.mode))
		else $error("mode changed while active");
	chk_start_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		$rose(o_fb.chan_active) |-> !o_fb.act_traverse)
		else $error("program started in traverse");
	chk_intr_path: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		st.chan == omc_pkg::CHAN_INTR && st.mode == omc_pkg::MODE_TRAVERSE && st.orig == omc_pkg::ORIG_AUTO
		|=> !o_fb.act_mdi)
		else $error("indirect path to mdi taken");
	chk_illegal_err: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		do_change && !legal && chg_mode != st.mode && !i_req.reset_req |=> o_fb.mode_err && $stable(st.chan))
		else $error("illegal change not flagged");
	chk_ref_ack: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_fb.ref_active |-> o_fb.act_traverse)
		else $error("reference ack outside traverse");
	chk_g74_active: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_fb.g74_run |-> o_fb.chan_active && !o_fb.act_traverse)
		else $error("g74 outside active program mode");
	chk_ready: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!i_req.reset_req |=> o_fb.ready)
		else $error("ready missing");

	cov_start: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) $rose(o_fb.chan_active));
	cov_intr_trav: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_fb.chan_intr && $rose(o_fb.act_traverse));
	cov_err: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) $rose(o_fb.mode_err));
	cov_deferred: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) st.pend ##1 !st.pend);
endmodule

// ---- testbench/omc_plc_model.sv ----
// machine-logic partner: holds the request bits and runs the reset handshake
`timescale 1ns/1ps
module omc_plc_model (
	input wire logic i_clk_sys,
	input wire omc_pkg::omc_fb_t i_fb,
	output omc_pkg::omc_req_t o_req
);
	initial o_req = '0;
	// ************************************
	// request changes, one edge after the call
	// ************************************
	task automatic put(input omc_pkg::omc_req_t v);
		@(posedge i_clk_sys);
		o_req <= v;
		@(posedge i_clk_sys);
		#1;
	endtask
	// reset counts as done only once chan_reset is seen
	task automatic wait_reset(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			if (i_fb.chan_reset === 1'b1) ok = 1'b1;
			else @(posedge i_clk_sys);
		end
	endtask
endmodule

// ---- testbench/omc_mode_ctrl_tb.sv ----
// self-checking bench of the operating-mode controller
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module omc_mode_ctrl_tb;
	logic i_clk_sys = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_block_end = 1'b0;
	logic i_prog_end = 1'b0;
	logic i_g74_done = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic [7:0] o_block_ptr;
	omc_pkg::omc_fb_t fb;
	omc_pkg::omc_req_t req;
	omc_pkg::omc_req_t r;
	logic [31:0] d;
	logic ok;
	int failures = 0;
	int num_checks = 0;
	always #10 i_clk_sys = ~i_clk_sys;
	omc_plc_model pm (.i_clk_sys(i_clk_sys), .i_fb(fb), .o_req(req));
	omc_mode_ctrl dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req(req), .i_block_end(i_block_end),
		.i_prog_end(i_prog_end), .i_g74_done(i_g74_done), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_fb(fb), .o_block_ptr(o_block_ptr));
	// ************************************
	// access tasks
	// ************************************
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask
	task automatic pulse_block_end();
		@(posedge i_clk_sys);
		i_block_end <= 1'b1;
		@(posedge i_clk_sys);
		i_block_end <= 1'b0;
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200us;
		failures++;
		summarize();
	end
	// ************************************
	// main sequence
	// ************************************
	initial begin
		r = '0;
		r.sel_auto = 1'b1;
		repeat (20) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h4)
		`CHK(fb.ready, 1'b1)
		rd(omc_pkg::ADDR_STATUS, d);
		`CHK(d, 32'h0000_0000)
		rd(omc_pkg::ADDR_FEEDBACK, d);
		`CHK(d, 32'h0001_1880)
		rd(4'hc, d);
		`CHK(d, 32'h0000_0000)
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0002);
		`CHK(fb.g74_run, 1'b0)
		r.sel_mdi = 1'b1;
		r.sel_traverse = 1'b1;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h1)
		`CHK(fb.motion_enable, 1'b1)
		r.sel_traverse = 1'b0;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h2)
		r.sel_mdi = 1'b0;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		r.mode_chg_disable = 1'b1;
		r.sel_mdi = 1'b1;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		r.mode_chg_disable = 1'b0;
		r.sel_mdi = 1'b0;
		pm.put(r);
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0001);
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h1)
		`CHK(fb.prog_run, 1'b1)
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0002);
		`CHK(fb.g74_run, 1'b1)
		pulse_block_end();
		pulse_block_end();
		`CHK(o_block_ptr, 8'h02)
		r.sel_mdi = 1'b1;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		r.stop_axes = 1'b1;
		pm.put(r);
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h2)
		`CHK(fb.stop_axes_cmd, 1'b1)
		@(posedge i_clk_sys);
		#1;
		`CHK(fb.mode_err, 1'b1)
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		r.stop_axes = 1'b0;
		pm.put(r);
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0004);
		`CHK(fb.mode_err, 1'b0)
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h2)
		r.sel_mdi = 1'b0;
		r.sel_traverse = 1'b1;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h1)
		r.ref_req = 1'b1;
		pm.put(r);
		`CHK(fb.ref_active, 1'b1)
		r.ref_req = 1'b0;
		r.sel_traverse = 1'b0;
		r.sel_mdi = 1'b1;
		pm.put(r);
		`CHK(fb.mode_err, 1'b1)
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h1)
		r.sel_mdi = 1'b0;
		pm.put(r);
		`CHK({fb.act_auto, fb.act_mdi, fb.act_traverse}, 3'h4)
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0001);
		r.stop_axes_spindles = 1'b1;
		pm.put(r);
		`CHK(fb.stop_spindles_cmd, 1'b1)
		r.stop_axes_spindles = 1'b0;
		r.reset_req = 1'b1;
		pm.put(r);
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h4)
		`CHK({fb.prep_halt, fb.stop_axes_cmd, fb.stop_spindles_cmd}, 3'h7)
		`CHK(fb.aux_discard, 1'b1)
		`CHK(o_block_ptr, omc_pkg::BLOCK_PTR_RESET)
		`CHK(fb.alarm_clear, 1'b1)
		`CHK(fb.ready, 1'b0)
		r.reset_req = 1'b0;
		pm.put(r);
		pm.wait_reset(ok);
		`CHK(ok, 1'b1)
		if (!ok) summarize();
		`CHK(fb.ready, 1'b1)
		wr(omc_pkg::ADDR_CTRL, 32'h0000_0001);
		r.block_end_stop_request = 1'b1;
		pm.put(r);
		`CHK(fb.chan_active, 1'b1)
		pulse_block_end();
		`CHK({fb.chan_reset, fb.chan_intr, fb.chan_active}, 3'h2)
		summarize();
	end
endmodule
